//--- logic/sbtc_pkg.sv
// Purpose: constants for the 16-bit timer with capture and two compares
// Assumes: 8-bit register port, one system clock
// Notes:   all registers clear to zero at reset
//
// Overview of operation
// - Filter needs four equal samples to change
// - Edge select: zero falling, one rising
// - Capture copies counter, sets capture flag
// - Capture off when capture value is top
// - Clock select: stop, prescale taps, external edges
// - External pin counts even when driven out
// - Force strobe applies output mode, non-PWM only
// - Force raises no flag, never clears counter
// - Force strobe bits always read zero
// - Counter accessed atomically via high staging byte
// - One staging byte shared by all words
// - Counter write blocks next-tick compare matches
// - Compares checked on each tick; match sets flag, and output in non-PWM modes only
// - Capture from pin or comparator, atomic read
// - Mask bit five enables capture interrupt
// - Mask bit two enables compare-B interrupt
// - Mask bits 7,6,4,3 read zero
// - Waveform mode picks sequence and top
// - Capture flag cleared by vector or write-one
package sbtc_pkg;
    // ----------------------------------------
    // Register addresses
    // ----------------------------------------
    localparam logic [7:0] ADDR_MASK   = 8'h6f;
    localparam logic [7:0] ADDR_CTRL   = 8'h81;
    localparam logic [7:0] ADDR_FORCE  = 8'h82;
    localparam logic [7:0] ADDR_CNT_L  = 8'h90;
    localparam logic [7:0] ADDR_CNT_H  = 8'h91;
    localparam logic [7:0] ADDR_ICR_L  = 8'h92;
    localparam logic [7:0] ADDR_ICR_H  = 8'h93;
    localparam logic [7:0] ADDR_OCRA_L = 8'h94;
    localparam logic [7:0] ADDR_OCRA_H = 8'h95;
    localparam logic [7:0] ADDR_OCRB_L = 8'h96;
    localparam logic [7:0] ADDR_OCRB_H = 8'h97;
    localparam logic [7:0] ADDR_FLAGS  = 8'h98;
    // ----------------------------------------
    // Fields and reset values
    // ----------------------------------------
    localparam int BIT_NF   = 7;
    localparam int BIT_ES   = 6;
    localparam int BIT_FOCA = 7;
    localparam int BIT_FOCB = 6;
    localparam logic [7:0] CTRL_WMASK = 8'hdf;
    localparam logic [7:0] MASK_WMASK = 8'h27;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    // Prescaler tap masks: tick when low bits all ones
    localparam logic [9:0] PRE_M8    = 10'h007;
    localparam logic [9:0] PRE_M64   = 10'h03f;
    localparam logic [9:0] PRE_M256  = 10'h0ff;
    localparam logic [9:0] PRE_M1024 = 10'h3ff;
    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_DIV1 = 3'h1;
    localparam logic [2:0] CS_DIV8 = 3'h2;
    localparam logic [2:0] CS_D64  = 3'h3;
    localparam logic [2:0] CS_D256 = 3'h4;
    localparam logic [2:0] CS_D1K  = 3'h5;
    localparam logic [2:0] CS_EXTF = 3'h6;
    localparam logic [2:0] CS_EXTR = 3'h7;
    localparam logic [3:0] WM_NORMAL = 4'h0;
    localparam logic [3:0] WM_CTC_A  = 4'h4;
    localparam logic [3:0] WM_CTC_I  = 4'hc;
    localparam logic [15:0] TOP_FULL = 16'hffff;
    localparam logic [15:0] TOP_8    = 16'h00ff;
    localparam logic [15:0] TOP_9    = 16'h01ff;
    localparam logic [15:0] TOP_10   = 16'h03ff;
    localparam logic [1:0] COM_TOG = 2'h1;
    localparam logic [1:0] COM_CLR = 2'h2;
    localparam logic [1:0] COM_SET = 2'h3;
endpackage

//--- logic/sbtc_timer.sv
// Purpose: 16-bit timer core with capture, two compares, masks
// Assumes: all inputs synchronous to CLK_I
// Notes:   PWM modes count up only; waveform shaping not built
`timescale 1ns/1ps
module sbtc_timer import sbtc_pkg::*; #(
    parameter int FILTER_LEN = 4
) (
    // Clock and reset
    input  wire logic       CLK_I,
    input  wire logic       RST_I,
    // Register port
    input  wire logic [7:0] ADDR_I,
    input  wire logic [7:0] WDATA_I,
    input  wire logic       WE_I,
    input  wire logic       RE_I,
    output logic      [7:0] RDATA_O,
    // Settings held outside this block
    input  wire logic [1:0] WGM_LOW_I,
    input  wire logic [1:0] COM_A_I,
    input  wire logic [1:0] COM_B_I,
    input  wire logic       GIE_I,
    input  wire logic [3:0] IRQ_ACK_I,
    // Pins
    input  wire logic       CAP_PIN_I,
    input  wire logic       ACMP_I,
    input  wire logic       ACMP_SEL_I,
    input  wire logic       EXT_CLK_I,
    output logic            CMP_A_O,
    output logic            CMP_B_O,
    output logic      [3:0] IRQ_O
);
    // ----------------------------------------
    // Parameter check
    // ----------------------------------------
    generate
        if (FILTER_LEN < 2 || FILTER_LEN > 15) begin : g_bad
            $error("FILTER_LEN out of range");
        end
    endgenerate

    // ----------------------------------------
    // State
    // ----------------------------------------
    // Flags order: capture, compare B, compare A, overflow
    typedef struct packed {
        logic [7:0]  mask;
        logic [7:0]  ctrl;
        logic [7:0]  temp;
        logic [15:0] cnt;
        logic [15:0] ocra;
        logic [15:0] ocrb;
        logic [15:0] icr;
        logic [3:0]  flags;
        logic [9:0]  pre;
        logic        ext_s;
        logic        ext_d;
        logic        cap_s;
        logic [3:0]  filt_n;
        logic        cap_f;
        logic        cap_d;
        logic        block;
        logic        oca;
        logic        ocb;
        logic [7:0]  rdata;
        logic [3:0]  irq;
    } sbtc_state_t;

    sbtc_state_t q;
    sbtc_state_t next_q;

    logic [3:0]  wm;
    logic [2:0]  cs;
    logic        pwm;
    logic        icr_top;
    logic [15:0] top;
    logic        tick;
    logic        cap_evt;
    logic        wr;
    logic        rd;
    logic        cnt_wr;
    logic        icr_wr;
    logic        force_wr;
    logic        hit_a;
    logic        hit_b;
    logic [3:0]  clr;
    logic [3:0]  set;

    function automatic logic com_apply(input logic [1:0] com, input logic cur);
        logic r;
        r = cur;
        if (com == COM_TOG) begin
            r = ~cur;
        end else if (com == COM_CLR) begin
            r = 1'b0;
        end else if (com == COM_SET) begin
            r = 1'b1;
        end
        return r;
    endfunction

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        next_q   = q;
        wr       = WE_I;
        rd       = RE_I;
        wm       = {q.ctrl[4:3], WGM_LOW_I};
        cs       = q.ctrl[2:0];
        pwm      = !(wm == WM_NORMAL || wm == WM_CTC_A || wm == WM_CTC_I);
        icr_top  = wm[3] & ~wm[0];
        cnt_wr   = wr && ADDR_I == ADDR_CNT_L;
        icr_wr   = wr && ADDR_I == ADDR_ICR_L;
        force_wr = wr && ADDR_I == ADDR_FORCE;
        clr      = IRQ_ACK_I;
        set      = 4'h0;

        // Top of count per waveform mode
        case (wm)
            4'h1, 4'h5: top = TOP_8;
            4'h2, 4'h6: top = TOP_9;
            4'h3, 4'h7: top = TOP_10;
            4'h4, 4'h9, 4'hb, 4'hf: top = q.ocra;
            4'h8, 4'ha, 4'hc, 4'he: top = q.icr;
            default: top = TOP_FULL;
        endcase

        // Free running prescaler and external edge detect
        next_q.pre   = q.pre + 10'h001;
        next_q.ext_s = EXT_CLK_I;
        next_q.ext_d = q.ext_s;
        case (cs)
            CS_DIV1: tick = 1'b1;
            CS_DIV8: tick = (q.pre & PRE_M8) == PRE_M8;
            CS_D64:  tick = (q.pre & PRE_M64) == PRE_M64;
            CS_D256: tick = (q.pre & PRE_M256) == PRE_M256;
            CS_D1K:  tick = q.pre == PRE_M1024;
            CS_EXTF: tick = q.ext_d & ~q.ext_s;
            CS_EXTR: tick = q.ext_s & ~q.ext_d;
            default: tick = 1'b0;
        endcase

        // Capture source, filter and edge
        next_q.cap_s = ACMP_SEL_I ? ACMP_I : CAP_PIN_I;
        if (!q.ctrl[BIT_NF]) begin
            next_q.cap_f  = q.cap_s;
            next_q.filt_n = 4'h0;
        end else if (q.cap_s == q.cap_f) begin
            next_q.filt_n = 4'h0;
        end else if (q.filt_n == 4'(FILTER_LEN - 1)) begin
            next_q.cap_f  = q.cap_s;
            next_q.filt_n = 4'h0;
        end else begin
            next_q.filt_n = q.filt_n + 4'h1;
        end
        next_q.cap_d = q.cap_f;
        cap_evt = !icr_top &&
            (q.ctrl[BIT_ES] ? (q.cap_f & ~q.cap_d) : (~q.cap_f & q.cap_d));
        if (cap_evt) begin
            next_q.icr = q.cnt;
            set[3]     = 1'b1;
        end

        // Counting, compare and overflow
        hit_a = tick && !q.block && q.cnt == q.ocra;
        hit_b = tick && !q.block && q.cnt == q.ocrb;
        if (tick) begin
            next_q.block = 1'b0;
            set[1] = hit_a;
            set[2] = hit_b;
            if (icr_top && q.cnt == top) begin
                set[3] = 1'b1;
            end
            if (pwm ? q.cnt == top : q.cnt == TOP_FULL) begin
                set[0] = 1'b1;
            end
            next_q.cnt = (q.cnt == top) ? 16'h0000 : q.cnt + 16'h0001;
            if (!pwm && hit_a) begin
                next_q.oca = com_apply(COM_A_I, q.oca);
            end
            if (!pwm && hit_b) begin
                next_q.ocb = com_apply(COM_B_I, q.ocb);
            end
        end

        // Forced compare: output only, no flag, no clear
        if (force_wr && !pwm) begin
            if (WDATA_I[BIT_FOCA]) begin
                next_q.oca = com_apply(COM_A_I, q.oca);
            end
            if (WDATA_I[BIT_FOCB]) begin
                next_q.ocb = com_apply(COM_B_I, q.ocb);
            end
        end

        // Register writes; high bytes stage in one shared byte
        if (wr) begin
            if (ADDR_I == ADDR_CTRL) begin
                next_q.ctrl = WDATA_I & CTRL_WMASK;
            end else if (ADDR_I == ADDR_MASK) begin
                next_q.mask = WDATA_I & MASK_WMASK;
            end else if (ADDR_I == ADDR_FLAGS) begin
                clr = clr | {WDATA_I[5], WDATA_I[2:0]};
            end else if (ADDR_I == ADDR_CNT_H || ADDR_I == ADDR_ICR_H ||
                         ADDR_I == ADDR_OCRA_H || ADDR_I == ADDR_OCRB_H) begin
                next_q.temp = WDATA_I;
            end else if (cnt_wr) begin
                next_q.cnt   = {q.temp, WDATA_I};
                next_q.block = 1'b1;
            end else if (icr_wr) begin
                next_q.icr = {q.temp, WDATA_I};
            end else if (ADDR_I == ADDR_OCRA_L) begin
                next_q.ocra = {q.temp, WDATA_I};
            end else if (ADDR_I == ADDR_OCRB_L) begin
                next_q.ocrb = {q.temp, WDATA_I};
            end
        end

        // Set beats clear in the same cycle
        next_q.flags = (q.flags & ~clr) | set;

        // Reads, one cycle latency; counter and capture low bytes load staging
        next_q.rdata = RESET_BYTE;
        if (rd) begin
            if (ADDR_I == ADDR_CTRL) begin
                next_q.rdata = q.ctrl;
            end else if (ADDR_I == ADDR_MASK) begin
                next_q.rdata = q.mask;
            end else if (ADDR_I == ADDR_FORCE) begin
                next_q.rdata = RESET_BYTE;
            end else if (ADDR_I == ADDR_FLAGS) begin
                next_q.rdata = {2'h0, q.flags[3], 2'h0, q.flags[2:0]};
            end else if (ADDR_I == ADDR_CNT_L) begin
                next_q.rdata = q.cnt[7:0];
                next_q.temp  = q.cnt[15:8];
            end else if (ADDR_I == ADDR_ICR_L) begin
                next_q.rdata = q.icr[7:0];
                next_q.temp  = q.icr[15:8];
            end else if (ADDR_I == ADDR_CNT_H || ADDR_I == ADDR_ICR_H) begin
                next_q.rdata = q.temp;
            end else if (ADDR_I == ADDR_OCRA_L) begin
                next_q.rdata = q.ocra[7:0];
            end else if (ADDR_I == ADDR_OCRA_H) begin
                next_q.rdata = q.ocra[15:8];
            end else if (ADDR_I == ADDR_OCRB_L) begin
                next_q.rdata = q.ocrb[7:0];
            end else if (ADDR_I == ADDR_OCRB_H) begin
                next_q.rdata = q.ocrb[15:8];
            end
        end

        // Interrupt lines gated by mask and global enable
        next_q.irq = next_q.flags & {q.mask[5], q.mask[2:0]} & {4{GIE_I}};
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign RDATA_O = q.rdata;
    assign CMP_A_O = q.oca;
    assign CMP_B_O = q.ocb;
    assign IRQ_O   = q.irq;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);

    AST_FILTER: assert property (
        $past(q.ctrl[BIT_NF]) && $past(q.ctrl[BIT_NF], 4) && $changed(q.cap_f)
        |-> $past(q.cap_s) == q.cap_f && $past(q.cap_s, 2) == q.cap_f &&
            $past(q.cap_s, 3) == q.cap_f && $past(q.cap_s, 4) == q.cap_f)
        else $error("filter changed early");
    AST_CAPTURE: assert property (
        cap_evt && !icr_wr |=> q.flags[3] && q.icr == $past(q.cnt))
        else $error("capture not taken");
    AST_NO_CAP: assert property (icr_top && !icr_wr |=> q.icr == $past(q.icr))
        else $error("capture while top");
    AST_FORCE_RD: assert property (rd && ADDR_I == ADDR_FORCE |=> RDATA_O == 8'h00)
        else $error("force reads nonzero");
    AST_FORCE_NF: assert property (
        force_wr && !tick && IRQ_ACK_I == 4'h0
        |=> q.flags[2:1] == $past(q.flags[2:1]) && q.cnt == $past(q.cnt))
        else $error("force changed flag");
    AST_BLOCK: assert property (
        cnt_wr ##1 (tick && !wr && IRQ_ACK_I == 4'h0)
        |=> q.flags[2:1] == $past(q.flags[2:1]))
        else $error("match after write");
    AST_MASK_RSVD: assert property (
        rd && ADDR_I == ADDR_MASK |=> RDATA_O[7:6] == 2'h0 && RDATA_O[4:3] == 2'h0)
        else $error("mask reserved set");
    AST_IRQ_B: assert property (IRQ_O[2] |-> q.flags[2] && $past(q.mask[2]) && $past(GIE_I))
        else $error("irq B without cause");
    AST_IRQ_C: assert property (q.flags[3] && q.mask[5] && GIE_I ##1 q.flags[3] |-> IRQ_O[3])
        else $error("irq capture missing");
    AST_DIV8: assert property (cs == CS_DIV8 && tick |-> q.pre[2:0] == 3'h7)
        else $error("div8 off phase");
    AST_ATOMIC: assert property (
        cnt_wr |=> q.cnt == {$past(q.temp), $past(WDATA_I)})
        else $error("counter write torn");

    COV_CAPTURE: cover property (cap_evt ##1 IRQ_O[3]);
    COV_FORCE:   cover property (force_wr && !pwm && WDATA_I[BIT_FOCA]);
    COV_WRAP:    cover property (tick && q.cnt == top);
    COV_MATCH_B: cover property (hit_b ##1 IRQ_O[2]);
endmodule

//--- tb/sbtc_pin_model.sv
// Purpose: far-side model of the capture and count-clock pins
// Assumes: the timer samples both pins on rising CLK_I edges
// Notes:   levels change just after an edge and are held whole cycles
`timescale 1ns/1ps
module sbtc_pin_model (
    // Clock
    input  wire logic clk_i,
    // Pins
    output logic      cap_o,
    output logic      ext_o
);
    initial begin
        cap_o = 1'b0;
        ext_o = 1'b0;
    end
    // ----------------------------------------
    // Pin drivers
    // ----------------------------------------
    // Half periods of four cycles stay well below half the clock rate
    task automatic ext_set(input logic lvl);
        @(posedge clk_i);
        ext_o <= lvl;
        repeat (4) @(posedge clk_i);
    endtask
    // Short holds model glitches for the noise filter
    task automatic cap_set(input logic lvl, input int n);
        @(posedge clk_i);
        cap_o <= lvl;
        repeat (n) @(posedge clk_i);
    endtask
endmodule

//--- tb/tb.sv
// Purpose: self-checking bench for the 16-bit timer core
// Assumes: pin model drives capture and count-clock pins
// Notes:   prescaled counts allow for the free-running prescaler phase
`timescale 1ns/1ps
module tb import sbtc_pkg::*;;
    typedef struct packed {
        logic [7:0] a;
        logic [7:0] d;
        logic       w;
        logic [7:0] e;
    } sbtc_row_t;
    logic        clk, rst, we, re, gie, acmp, acmp_sel, cap, ext, cmp_a, cmp_b;
    logic [7:0]  addr, wdata, rdata, b;
    logic [1:0]  wgm_low, com_a, com_b;
    logic [3:0]  irq_ack, irq;
    logic [15:0] v;
    int          n_fail, n_tests;
    int          dv [6] = '{0, 1, 8, 64, 256, 1024};
    sbtc_row_t   rows [12] = '{
        '{ADDR_MASK, 8'h00, 1'b0, 8'h00}, '{ADDR_CTRL, 8'h00, 1'b0, 8'h00},
        '{ADDR_FORCE, 8'h00, 1'b0, 8'h00}, '{ADDR_FLAGS, 8'h00, 1'b0, 8'h00},
        '{ADDR_CNT_L, 8'h00, 1'b0, 8'h00}, '{ADDR_MASK, 8'hff, 1'b1, 8'h27},
        '{ADDR_MASK, 8'h00, 1'b1, 8'h00}, '{ADDR_CTRL, 8'h5f, 1'b1, 8'h5f},
        '{ADDR_CTRL, 8'hc0, 1'b1, 8'hc0}, '{ADDR_FORCE, 8'hc0, 1'b1, 8'h00},
        '{8'h50, 8'hff, 1'b1, 8'h00}, '{ADDR_CTRL, 8'h00, 1'b1, 8'h00}};

    sbtc_timer #(.FILTER_LEN(4)) dut_u (
        .CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WE_I(we),
        .RE_I(re), .RDATA_O(rdata), .WGM_LOW_I(wgm_low), .COM_A_I(com_a),
        .COM_B_I(com_b), .GIE_I(gie), .IRQ_ACK_I(irq_ack), .CAP_PIN_I(cap),
        .ACMP_I(acmp), .ACMP_SEL_I(acmp_sel), .EXT_CLK_I(ext), .CMP_A_O(cmp_a),
        .CMP_B_O(cmp_b), .IRQ_O(irq));
    sbtc_pin_model pins_u (.clk_i(clk), .cap_o(cap), .ext_o(ext));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ----------------------------------------
    // Bus cycles and comparisons
    // ----------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        we <= 1'b1;
        @(posedge clk);
        we <= 1'b0;
    endtask
    // High byte first: the low write commits the word
    task automatic wr16(input logic [7:0] a, input logic [15:0] d);
        wr(a + 8'h01, d[15:8]);
        wr(a, d[7:0]);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        re <= 1'b1;
        @(posedge clk);
        re <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic rd16(input logic [7:0] a, output logic [15:0] d);
        rd(a, d[7:0]);
        rd(a + 8'h01, d[15:8]);
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            n_fail++;
        end
    endtask
    task automatic rng(input logic [15:0] got, input int lo, input int hi);
        n_tests++;
        if ($isunknown(got) || got < lo || got > hi) begin
            $display("wrong value at %0t: count %h out of range", $time, got);
            n_fail++;
        end
    endtask
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Watchdog
    // ----------------------------------------
    initial begin
        #600us;
        n_fail++;
        final_report();
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {rst, we, re, gie, acmp, acmp_sel} = 6'h20;
        {addr, wdata, wgm_low, com_a, com_b, irq_ack} = '0;
        n_fail = 0;
        n_tests = 0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        gie <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i].w) begin
                wr(rows[i].a, rows[i].d);
            end
            rd(rows[i].a, b);
            chk({8'h00, b}, {8'h00, rows[i].e});
        end
        wr16(ADDR_CNT_L, 16'h1234);
        rd16(ADDR_CNT_L, v);
        chk(v, 16'h1234);
        wr16(ADDR_OCRA_L, 16'habcd);
        rd16(ADDR_OCRA_L, v);
        chk(v, 16'habcd);
        wr(ADDR_OCRA_H, 8'h56);
        wr(ADDR_CNT_L, 8'h78);
        rd16(ADDR_CNT_L, v);
        chk(v, 16'h5678);
        rd(ADDR_ICR_H, b);
        chk({8'h00, b}, 16'h0056);
        for (int cs = 0; cs < 6; cs++) begin
            wr16(ADDR_CNT_L, 16'h0000);
            wr(ADDR_CTRL, 8'(cs));
            repeat (2048) @(posedge clk);
            wr(ADDR_CTRL, 8'h00);
            rd16(ADDR_CNT_L, v);
            rng(v, cs ? 2048 / dv[cs] - 1 : 0, cs ? 2048 / dv[cs] + 4 : 0);
        end
        for (int cs = 6; cs < 8; cs++) begin
            wr16(ADDR_CNT_L, 16'h0000);
            wr(ADDR_CTRL, 8'(cs));
            pins_u.ext_set(1'b1);
            rd16(ADDR_CNT_L, v);
            chk(v, (cs == 7) ? 16'h0001 : 16'h0000);
            pins_u.ext_set(1'b0);
            rd16(ADDR_CNT_L, v);
            chk(v, 16'h0001);
        end
        wr(ADDR_FLAGS, 8'h27);
        wr(ADDR_MASK, 8'h20);
        wr16(ADDR_CNT_L, 16'h0abc);
        wr(ADDR_CTRL, 8'h40);
        pins_u.cap_set(1'b1, 6);
        chk({12'h000, irq}, 16'h0008);
        rd16(ADDR_ICR_L, v);
        chk(v, 16'h0abc);
        rd(ADDR_FLAGS, b);
        chk({8'h00, b}, 16'h0020);
        @(posedge clk);
        irq_ack <= 4'h8;
        @(posedge clk);
        irq_ack <= 4'h0;
        rd(ADDR_FLAGS, b);
        chk({8'h00, b}, 16'h0000);
        wr16(ADDR_CNT_L, 16'h0111);
        pins_u.cap_set(1'b0, 6);
        rd16(ADDR_ICR_L, v);
        chk(v, 16'h0abc);
        wr(ADDR_CTRL, 8'h00);
        pins_u.cap_set(1'b1, 6);
        pins_u.cap_set(1'b0, 6);
        rd16(ADDR_ICR_L, v);
        chk(v, 16'h0111);
        wr(ADDR_FLAGS, 8'h20);
        rd(ADDR_FLAGS, b);
        chk({8'h00, b}, 16'h0000);
        acmp_sel <= 1'b1;
        wr16(ADDR_CNT_L, 16'h0333);
        acmp <= 1'b1;
        repeat (6) @(posedge clk);
        acmp <= 1'b0;
        repeat (6) @(posedge clk);
        acmp_sel <= 1'b0;
        rd16(ADDR_ICR_L, v);
        chk(v, 16'h0333);
        wr(ADDR_CTRL, 8'hc0);
        wr16(ADDR_CNT_L, 16'h0222);
        pins_u.cap_set(1'b1, 1);
        pins_u.cap_set(1'b0, 6);
        rd16(ADDR_ICR_L, v);
        chk(v, 16'h0333);
        pins_u.cap_set(1'b1, 8);
        rd16(ADDR_ICR_L, v);
        chk(v, 16'h0222);
        wr(ADDR_FLAGS, 8'h20);
        wr(ADDR_CTRL, 8'h18);
        pins_u.cap_set(1'b0, 6);
        rd(ADDR_FLAGS, b);
        chk({8'h00, b}, 16'h0000);
        wr(ADDR_MASK, 8'h04);
        com_a <= 2'h1;
        com_b <= 2'h1;
        wr16(ADDR_OCRB_L, 16'h0010);
        wr16(ADDR_CNT_L, 16'h0000);
        wr(ADDR_CTRL, 8'h01);
        repeat (40) @(posedge clk);
        #1 chk({12'h000, irq}, 16'h0004);
        chk({15'h0000, cmp_b}, 16'h0001);
        @(posedge clk);
        irq_ack <= 4'h4;
        @(posedge clk);
        irq_ack <= 4'h0;
        wr16(ADDR_CNT_L, 16'h0010);
        repeat (20) @(posedge clk);
        rd(ADDR_FLAGS, b);
        chk({8'h00, b}, 16'h0000);
        wr(ADDR_MASK, 8'h06);
        wr(ADDR_CTRL, 8'h08);
        wr16(ADDR_CNT_L, 16'h0005);
        wr(ADDR_FORCE, 8'h80);
        repeat (2) @(posedge clk);
        #1 chk({14'h0000, cmp_a, irq[1]}, 16'h0002);
        rd16(ADDR_CNT_L, v);
        chk(v, 16'h0005);
        rd(ADDR_FLAGS, b);
        chk({8'h00, b}, 16'h0000);
        wr(ADDR_FORCE, 8'h80);
        wgm_low <= 2'h1;
        com_b <= 2'h2;
        wr(ADDR_FORCE, 8'hc0);
        wgm_low <= 2'h0;
        wr(ADDR_FORCE, 8'h40);
        repeat (2) @(posedge clk);
        #1 chk({14'h0000, cmp_a, cmp_b}, 16'h0000);
        wr16(ADDR_OCRA_L, 16'h0004);
        wr16(ADDR_CNT_L, 16'h0000);
        wr(ADDR_CTRL, 8'h09);
        repeat (20) @(posedge clk);
        wr(ADDR_CTRL, 8'h08);
        rd16(ADDR_CNT_L, v);
        rng(v, 0, 4);
        rd(ADDR_FLAGS, b);
        chk({8'h00, b}, 16'h0002);
        wr(ADDR_FLAGS, 8'h27);
        wr16(ADDR_CNT_L, 16'hfffe);
        wr(ADDR_CTRL, 8'h01);
        wr(ADDR_CTRL, 8'h00);
        rd(ADDR_FLAGS, b);
        chk({8'h00, b}, 16'h0001);
        rd16(ADDR_CNT_L, v);
        chk(v, 16'h0000);
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        rd(ADDR_CTRL, b);
        chk({8'h00, b}, 16'h0000);
        final_report();
    end
endmodule
